// *** rss_pkg.sv ***
// constants and types for the rotate/subtract/skip/set execution datapath
package rss_pkg;

    localparam int          DATA_W      = 8;
    localparam int          ADDR_W      = 8;
    localparam int          REG_ADDR_W  = 4;

    // software register offsets
    localparam logic [3:0]  OFS_WORK    = 4'h0;
    localparam logic [3:0]  OFS_STATUS  = 4'h1;

    // values after reset, the set-all pattern and the decrement step
    localparam logic [7:0]  WORK_RST    = 8'h00;
    localparam logic [3:0]  STATUS_RST  = 4'h0;
    localparam logic [7:0]  ALL_ONES    = 8'hFF;
    localparam logic [7:0]  DEC_STEP    = 8'h01;

    // cycle counts of an instruction
    localparam int          CYC_PLAIN   = 1;
    localparam int          CYC_SKIP    = 2;

    typedef enum logic [2:0] {
        OP_NONE    = 3'h0,
        OP_ROTW    = 3'h1,
        OP_SUBW    = 3'h2,
        OP_SUBM    = 3'h3,
        OP_DECM    = 3'h4,
        OP_DECW    = 3'h5,
        OP_SETALL  = 3'h6,
        OP_SETBIT  = 3'h7
    } rss_op_t;

    // status word, bit 3 down to bit 0
    typedef struct packed {
        logic signedWrapBit;
        logic nullResultBit;
        logic halfCarryBit;
        logic borrowBit;
    } rss_status_t;

    typedef struct packed {
        rss_op_t             op;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   memData;
        logic [2:0]          bitSel;
    } rss_req_t;

    typedef struct packed {
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   data;
    } rss_memwr_t;

    typedef enum logic [1:0] {
        ST_RUN   = 2'b01,
        ST_DUMMY = 2'b10
    } rss_state_t;

endpackage

// *** rss_exec.sv ***
// execution datapath: rotate, subtract with borrow, decrement-skip, set
module rss_exec
    import rss_pkg::*;
(
    input  wire logic                  core_clk,
    input  wire logic                  rstn,
    input  wire logic                  execValid,
    input  wire rss_req_t              execReq,
    output logic                       memWe,
    output rss_memwr_t                 memWr,
    output logic [DATA_W-1:0]          workReg,
    output rss_status_t                status,
    output logic                       skipTaken,
    output logic                       dummyCycle,
    output logic                       instrDone,
    input  wire logic [REG_ADDR_W-1:0] regAddr,
    input  wire logic [DATA_W-1:0]     regWdata,
    input  wire logic                  regWe,
    input  wire logic                  regRe,
    output logic [DATA_W-1:0]          regRdata
);


    // nine-bit difference a - m - ~c, bit 8 is the borrow out
    function automatic logic [8:0] subBorrow(input logic [7:0] a,
                                             input logic [7:0] m,
                                             input logic       c);
        subBorrow = {1'b0, a} - {1'b0, m} - {8'h00, ~c};
    endfunction

    function automatic logic [7:0] bitMask(input logic [2:0] sel);
        bitMask = 8'h01 << sel;
    endfunction

    rss_state_t           state_q,    state_d;
    logic [DATA_W-1:0]    workReg_q,  workReg_d;
    rss_status_t          status_q,   status_d;
    logic                 memWe_q,    memWe_d;
    rss_memwr_t           memWr_q,    memWr_d;
    logic                 skip_q,     skip_d;
    logic                 done_q,     done_d;
    logic                 dummy_q,    dummy_d;
    logic [DATA_W-1:0]    rdata_q,    rdata_d;

    logic                 execTake;
    logic [8:0]           subRes;
    logic [4:0]           subLow;
    logic [7:0]           decRes;
    logic                 wrapOut;

    // requests are ignored during the dummy cycle
    assign execTake = execValid && (state_q == ST_RUN);
    assign subRes   = subBorrow(workReg_q, execReq.memData, status_q.borrowBit);
    assign subLow   = {1'b0, workReg_q[3:0]} - {1'b0, execReq.memData[3:0]}
                      - {4'h0, ~status_q.borrowBit};
    assign decRes   = execReq.memData - DEC_STEP;
    assign wrapOut  = (workReg_q[7] != execReq.memData[7])
                      && (subRes[7] != workReg_q[7]);

    always_comb begin
        state_d   = ST_RUN;
        workReg_d = workReg_q;
        status_d  = status_q;
        memWe_d   = 1'b0;
        memWr_d   = memWr_q;
        skip_d    = 1'b0;
        done_d    = 1'b0;
        dummy_d   = 1'b0;
        rdata_d   = '0;
        if (regRe) begin
            unique case (regAddr)
                OFS_WORK:   rdata_d = workReg_q;
                OFS_STATUS: rdata_d = {4'h0, status_q};
                default:    rdata_d = '0;
            endcase
        end
        // software writes lose against a same-cycle instruction
        if (regWe && !execTake) begin
            if (regAddr == OFS_WORK) begin
                workReg_d = regWdata;
            end
            if (regAddr == OFS_STATUS) begin
                status_d = rss_status_t'(regWdata[3:0]);
            end
        end
        unique case (state_q)
            ST_DUMMY: begin
                done_d = 1'b1;
            end
            ST_RUN: begin
                if (execTake) begin
                    done_d       = 1'b1;
                    memWr_d.addr = execReq.addr;
                    unique case (execReq.op)
                        OP_ROTW: begin
                            workReg_d = {status_q.borrowBit, execReq.memData[7:1]};
                            status_d.borrowBit = execReq.memData[0];
                        end
                        OP_SUBW, OP_SUBM: begin
                            if (execReq.op == OP_SUBW) begin
                                workReg_d = subRes[7:0];
                            end else begin
                                memWe_d      = 1'b1;
                                memWr_d.data = subRes[7:0];
                            end
                            status_d.signedWrapBit = wrapOut;
                            status_d.nullResultBit = (subRes[7:0] == 8'h00);
                            status_d.halfCarryBit  = ~subLow[4];
                            status_d.borrowBit     = ~subRes[8];
                        end
                        OP_DECM, OP_DECW: begin
                            if (execReq.op == OP_DECM) begin
                                memWe_d      = 1'b1;
                                memWr_d.data = decRes;
                            end else begin
                                workReg_d = decRes;
                            end
                            if (decRes == 8'h00) begin
                                skip_d  = 1'b1;
                                done_d  = 1'b0;
                                dummy_d = 1'b1;
                                state_d = ST_DUMMY;
                            end
                        end
                        OP_SETALL: begin
                            memWe_d      = 1'b1;
                            memWr_d.data = ALL_ONES;
                        end
                        OP_SETBIT: begin
                            memWe_d      = 1'b1;
                            memWr_d.data = execReq.memData | bitMask(execReq.bitSel);
                        end
                        OP_NONE: begin
                            done_d = 1'b1;
                        end
                    endcase
                end
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_q   <= ST_RUN;
            workReg_q <= WORK_RST;
            status_q  <= rss_status_t'(STATUS_RST);
            memWe_q   <= 1'b0;
            memWr_q   <= '0;
            skip_q    <= 1'b0;
            done_q    <= 1'b0;
            dummy_q   <= 1'b0;
            rdata_q   <= '0;
        end else begin
            state_q   <= state_d;
            workReg_q <= workReg_d;
            status_q  <= status_d;
            memWe_q   <= memWe_d;
            memWr_q   <= memWr_d;
            skip_q    <= skip_d;
            done_q    <= done_d;
            dummy_q   <= dummy_d;
            rdata_q   <= rdata_d;
        end
    end

    assign memWe      = memWe_q;
    assign memWr      = memWr_q;
    assign workReg    = workReg_q;
    assign status     = status_q;
    assign skipTaken  = skip_q;
    assign dummyCycle = dummy_q;
    assign instrDone  = done_q;
    assign regRdata   = rdata_q;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    logic isSub;
    assign isSub = (execReq.op == OP_SUBW) || (execReq.op == OP_SUBM);

    // independent reference for the signed wrap and low nibble borrow
    logic signed [9:0]    sgnDiff;
    logic                 sgnWrap;
    logic                 lowNoBorrow;
    assign sgnDiff     = $signed({{2{workReg_q[7]}}, workReg_q})
                         - $signed({{2{execReq.memData[7]}}, execReq.memData})
                         - $signed({9'h000, ~status_q.borrowBit});
    assign sgnWrap     = (sgnDiff > 10'sh07F) || (sgnDiff < -10'sh080);
    assign lowNoBorrow = {1'b0, workReg_q[3:0]}
                         >= ({1'b0, execReq.memData[3:0]} + {4'h0, ~status_q.borrowBit});

    // results of each operation, one cycle after it is taken

    AST_ROT_RESULT: assert property (
        execTake && execReq.op == OP_ROTW |=> workReg_q == {$past(status_q.borrowBit),
            $past(execReq.memData[7:1])} && status_q.borrowBit == $past(execReq.memData[0])
            && !memWe_q)
        else $error("rotate result or borrow wrong");

    AST_SUBW_RESULT: assert property (
        execTake && execReq.op == OP_SUBW |=> workReg_q == $past(subRes[7:0]) && !memWe_q
            && status_q.nullResultBit == ($past(subRes[7:0]) == 8'h00))
        else $error("subtract to work result wrong");

    AST_SUB_BORROW: assert property (
        execTake && isSub |=> status_q.borrowBit == !$past(subRes[8]))
        else $error("borrow after subtract wrong");

    AST_SUB_FLAGS: assert property (
        execTake && isSub |=> status_q.signedWrapBit == $past(sgnWrap)
            && status_q.halfCarryBit == $past(lowNoBorrow))
        else $error("subtract wrap or half carry flag wrong");

    AST_SUBM_RESULT: assert property (
        execTake && execReq.op == OP_SUBM |=> memWe_q && memWr_q.data == $past(subRes[7:0])
            && workReg_q == $past(workReg_q))
        else $error("subtract to memory result wrong");

    AST_DECM_RESULT: assert property (
        execTake && execReq.op == OP_DECM |=> memWe_q && memWr_q.data == $past(decRes)
            && status_q == $past(status_q) && skip_q == ($past(decRes) == 8'h00))
        else $error("decrement memory result wrong");

    AST_SKIP_DUMMY: assert property (
        skip_q |-> dummyCycle && !instrDone ##1 instrDone && !dummyCycle)
        else $error("skip did not take two cycles");

    AST_DECW_RESULT: assert property (
        execTake && execReq.op == OP_DECW |=> workReg_q == $past(decRes) && !memWe_q
            && status_q == $past(status_q) && skip_q == (workReg_q == 8'h00))
        else $error("decrement to work result wrong");

    AST_SETALL: assert property (
        execTake && execReq.op == OP_SETALL |=> memWe_q && memWr_q.data == ALL_ONES
            && status_q == $past(status_q))
        else $error("set all result wrong");

    AST_SETBIT: assert property (
        execTake && execReq.op == OP_SETBIT |=> memWe_q
            && memWr_q.data == ($past(execReq.memData) | bitMask($past(execReq.bitSel)))
            && status_q == $past(status_q))
        else $error("set bit result wrong");

    AST_DEC_ONECYCLE: assert property (
        execTake && (execReq.op == OP_DECM || execReq.op == OP_DECW) && decRes != 8'h00
            |=> instrDone && !dummyCycle && !skip_q)
        else $error("nonzero decrement not single cycle");

    AST_SKIP_ONLY_DEC: assert property (
        skip_q |-> $past(execTake) && ($past(execReq.op) == OP_DECM
            || $past(execReq.op) == OP_DECW) && $past(decRes) == 8'h00)
        else $error("skip without a zero decrement");

    AST_DUMMY_REFUSE: assert property (
        dummyCycle |=> !memWe_q && !skip_q && instrDone)
        else $error("request taken during dummy cycle");

    AST_DONE_ONE: assert property (
        instrDone |-> !skip_q)
        else $error("done and skip in one cycle");

    AST_OP_NONE: assert property (
        execTake && execReq.op == OP_NONE |=> instrDone && !memWe_q && !skip_q
            && status_q == $past(status_q) && workReg_q == $past(workReg_q))
        else $error("empty operation changed state");

    AST_MEMWR_ADDR: assert property (
        execTake |=> memWr_q.addr == $past(execReq.addr))
        else $error("memory write address wrong");

    // software port
    AST_SW_WRITE: assert property (
        regWe && !execTake && regAddr == OFS_WORK |=> workReg_q == $past(regWdata))
        else $error("software work register write lost");

    AST_SW_LOST: assert property (
        regWe && execTake && execReq.op inside {OP_NONE, OP_DECM, OP_SETALL, OP_SETBIT}
            |=> workReg_q == $past(workReg_q) && status_q == $past(status_q))
        else $error("software write not dropped beside an instruction");

    AST_REG_READ: assert property (
        regRe && regAddr == OFS_WORK |=> regRdata == $past(workReg_q))
        else $error("work register read data wrong");

    AST_RDATA_IDLE: assert property (
        !regRe |=> regRdata == 8'h00)
        else $error("read data outside a read");

    // main scenarios

    COV_SKIP: cover property (execTake && execReq.op == OP_DECM && decRes == 8'h00
        ##1 skip_q ##1 instrDone);
    COV_SUB_NEG: cover property (execTake && isSub ##1 !status_q.borrowBit);
    COV_ROT: cover property (execTake && execReq.op == OP_ROTW ##1 execTake
        && execReq.op == OP_ROTW);
    COV_REG_RMW: cover property (regWe && !execTake ##1 regRe);
    COV_REFUSED: cover property (dummyCycle && execValid);

endmodule

// *** rss_mem_model.sv ***
// data memory model that answers the execution datapath
module rss_mem_model
    import rss_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rdEn,
    input  wire logic [ADDR_W-1:0] rdAddr,
    output logic      [DATA_W-1:0] rdData,
    input  wire logic              memWe,
    input  wire rss_memwr_t        memWr
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [DATA_W-1:0] mem [256];
    // unselected read port shows inverted data, never a stale byte
    assign rdData = rdEn ? mem[rdAddr] : ~mem[rdAddr];
    initial begin
        foreach (mem[i]) mem[i] = 8'h00;
    end
    always @(posedge core_clk) begin
        if (memWe) begin
            mem[memWr.addr] <= memWr.data;
        end
    end
    task automatic load(input logic [7:0] a, input logic [7:0] d);
        mem[a] = d;
    endtask
endmodule

// *** tb_rss_exec.sv ***
// self-checking bench for the rotate, subtract, skip and set datapath
module tb_rss_exec
    import rss_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk, rstn, execValid, regWe, regRe, sk, d1, d2, z, du;
    logic        memWe, skipTaken, dummyCycle, instrDone;
    rss_op_t     op;
    logic [7:0]  addr, mdat, workReg, regWdata, regRdata, v;
    logic [2:0]  bitSel;
    logic [3:0]  regAddr;
    rss_memwr_t  memWr;
    rss_status_t status;
    rss_req_t    execReq;
    int          n_mismatch = 0;
    int          checks = 0;
    logic [7:0]  sw [4] = '{8'h50, 8'h10, 8'h80, 8'h05};
    logic [7:0]  sm [4] = '{8'h20, 8'h20, 8'h01, 8'h04};
    logic [7:0]  sr [4] = '{8'h30, 8'hEF, 8'h7F, 8'h00};
    logic [3:0]  ss [4] = '{4'h3, 4'h0, 4'h9, 4'h7};
    logic        sc [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    logic [7:0]  dm [4] = '{8'h01, 8'h05, 8'h01, 8'h05};
    assign execReq = '{op: op, addr: addr, memData: mdat, bitSel: bitSel};

    rss_exec dut (.core_clk(core_clk), .rstn(rstn), .execValid(execValid),
        .execReq(execReq), .memWe(memWe), .memWr(memWr), .workReg(workReg),
        .status(status), .skipTaken(skipTaken), .dummyCycle(dummyCycle),
        .instrDone(instrDone), .regAddr(regAddr), .regWdata(regWdata),
        .regWe(regWe), .regRe(regRe), .regRdata(regRdata));
    rss_mem_model mdl (.core_clk(core_clk), .rdEn(execValid), .rdAddr(addr),
        .rdData(mdat), .memWe(memWe), .memWr(memWr));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("mismatches %0d, checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regWe <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge core_clk);
        regWe <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge core_clk);
        regRe <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRe <= 1'b0;
        #1 v = regRdata;
    endtask
    // hold keeps a set-all request on the next byte during the following cycle
    task automatic ex(input rss_op_t o, input logic [7:0] a, input logic [2:0] b, input bit hold);
        @(posedge core_clk);
        execValid <= 1'b1;
        op <= o;
        addr <= a;
        bitSel <= b;
        @(posedge core_clk);
        execValid <= hold;
        op <= OP_SETALL;
        addr <= a + 8'h01;
        #1 sk = skipTaken;
        d1 = instrDone;
        du = dummyCycle;
        @(posedge core_clk);
        execValid <= 1'b0;
        #1 d2 = instrDone;
    endtask

    initial begin
        rstn = 1'b0;
        execValid = 1'b0;
        regWe = 1'b0;
        regRe = 1'b0;
        op = OP_NONE;
        addr = 8'h00;
        bitSel = 3'h0;
        regAddr = 4'h0;
        regWdata = 8'h00;
        repeat (16) @(posedge core_clk);
        chk("reset work", workReg, WORK_RST);
        chk("reset status", status, STATUS_RST);
        rstn <= 1'b1;
        wr(OFS_STATUS, 8'h0B);
        rd(OFS_STATUS);
        chk("status read", v, 8'h0B);
        rd(4'hF);
        chk("unmapped read", v, 8'h00);
        mdl.load(8'h10, 8'h35);
        wr(OFS_WORK, 8'h00);
        ex(OP_ROTW, 8'h10, 3'h0, 1'b0);
        chk("rotate work", workReg, 8'h9A);
        chk("rotate flag", status.borrowBit, 8'h01);
        chk("rotate mem", mdl.mem[8'h10], 8'h35);
        rd(OFS_WORK);
        chk("work read", v, 8'h9A);
        for (int i = 0; i < 4; i++) begin
            mdl.load(8'h20, sm[i]);
            wr(OFS_WORK, sw[i]);
            wr(OFS_STATUS, {7'h00, sc[i]});
            ex(i < 2 ? OP_SUBW : OP_SUBM, 8'h20, 3'h0, 1'b0);
            chk("sub work", workReg, i < 2 ? sr[i] : sw[i]);
            chk("sub mem", mdl.mem[8'h20], i < 2 ? sm[i] : sr[i]);
            chk("sub flags", status, ss[i]);
        end
        wr(OFS_STATUS, 8'h0A);
        for (int i = 0; i < 4; i++) begin
            mdl.load(8'h30, dm[i]);
            mdl.load(8'h31, 8'h00);
            ex(i < 2 ? OP_DECM : OP_DECW, 8'h30, 3'h0, i == 0);
            z = (dm[i] == 8'h01);
            chk("skip", sk, z);
            chk("done first", d1, !z);
            chk("done second", d2, z);
            chk("dummy", du, z);
            chk("dec mem", mdl.mem[8'h30], i < 2 ? dm[i] - DEC_STEP : dm[i]);
            if (i > 1) chk("dec work", workReg, dm[i] - DEC_STEP);
            chk("request in dummy", mdl.mem[8'h31], 8'h00);
            chk("dec flags", status, 4'hA);
        end
        mdl.load(8'h50, 8'h03);
        fork
            wr(OFS_WORK, 8'h55);
            ex(OP_DECM, 8'h50, 3'h0, 1'b0);
        join
        chk("write beside instruction", workReg, 8'h04);
        chk("dec beside write", mdl.mem[8'h50], 8'h02);
        ex(OP_SETALL, 8'h40, 3'h0, 1'b0);
        chk("set all", mdl.mem[8'h40], ALL_ONES);
        chk("set all flags", status, 4'hA);
        for (int i = 0; i < 8; i++) begin
            ex(OP_SETBIT, 8'h41, i[2:0], 1'b0);
            chk("set bit", mdl.mem[8'h41], 8'hFF >> (7 - i));
        end
        chk("set bit flags", status, 4'hA);
        report_and_stop();
    end

    initial begin
        #100000;
        n_mismatch++;
        report_and_stop();
    end
endmodule
